// [ahsl_top.v]
// AHB-Lite register front end, privilege gate and three-axis homing control.
`timescale 1ns/1ns
`include "ahsl_map.vh"
module ahsl_top #(
  parameter CW = 32
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave.
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Switches, index 0 Z, 1 X, 2 Y.
  input wire [2:0] dec_sw,
  input wire [2:0] zero_sw,
  // Drives.
  output reg [2:0] step,
  output reg [2:0] dir,
  output reg [CW-1:0] search_speed
);
  reg [7:0] sensor_cfg;
  reg [7:0] dir_cfg;
  reg [1:0] mode;
  reg [2:0] priv;
  reg [1:0] axsel;
  reg [CW-1:0] tn_pos [0:2];
  reg [CW-1:0] tn_neg [0:2];
  reg [CW-1:0] mc_pos [0:2];
  reg [CW-1:0] mc_neg [0:2];
  reg [CW-1:0] zero_c [0:2];
  reg [CW-1:0] ref1 [0:2];
  reg [CW-1:0] ref2 [0:2];
  reg [CW-1:0] ref3 [0:2];
  reg [CW-1:0] tofs [0:2];
  reg [CW-1:0] low_speed;
  reg [CW-1:0] init_speed;
  reg [12:0] alarm;
  reg [4:0] op_req_ok;
  reg [2:0] usb_wlevel;
  reg upg_pending;
  reg [1:0] tgt_sel;
  reg [2:0] home_start;
  reg [2:0] move_start;
  reg [2:0] jog_pos;
  reg [2:0] jog_neg;
  reg dph_valid;
  reg dph_write;
  reg [11:0] dph_addr;
  reg [31:0] next_rdata;
  reg [CW-1:0] target [0:2];
  wire [2:0] ax_step;
  wire [2:0] ax_dir;
  wire [2:0] ax_homing;
  wire [2:0] ax_homed;
  wire [2:0] ax_slow;
  wire [5:0] ax_method;
  wire [11:0] ax_alarm;
  wire [CW*3-1:0] ax_mcoord;
  wire ap_valid;
  wire wr;
  wire jog_auto;
  wire [4:0] op_allowed;
  wire [2:0] has_sw;
  integer i;

  assign ap_valid = hsel && htrans[1] && hready;
  assign wr = dph_valid && dph_write;
  assign jog_auto = (mode == `AHSL_MODE_JOG) || (mode == `AHSL_MODE_AUTO);
  // Operations: 0 init, 1 extract, 2 solidify, 3 upgrade/memory, 4 USB send.
  assign op_allowed[0] = (priv == `AHSL_LVL_MFR);
  assign op_allowed[1] = (priv >= `AHSL_LVL_MFR) && (priv <= `AHSL_LVL_OPR);
  assign op_allowed[2] = (priv >= `AHSL_LVL_MFR) && (priv <= `AHSL_LVL_OPR);
  assign op_allowed[3] = (priv == `AHSL_LVL_MFR);
  assign op_allowed[4] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : axis
      assign has_sw[g] = sensor_cfg[`AHSL_DEC_LSB + 2 - g] | sensor_cfg[`AHSL_ZER_LSB + 2 - g];
      ahsl_axis #(.CW(CW)) u_axis (
        .hclk(hclk),
        .hresetn(hresetn),
        .dec_fitted(sensor_cfg[`AHSL_DEC_LSB + 2 - g]),
        .zero_fitted(sensor_cfg[`AHSL_ZER_LSB + 2 - g]),
        .dir_neg(dir_cfg[`AHSL_DIR_LSB + 2 - g]),
        .dec_level(dir_cfg[`AHSL_LVL_LSB + 2 - g]),
        .no_modify(dir_cfg[`AHSL_NOMOD_BIT]),
        .jog_auto(jog_auto),
        .tn_pos_limit(tn_pos[g]),
        .tn_neg_limit(tn_neg[g]),
        .mc_pos_limit(mc_pos[g]),
        .mc_neg_limit(mc_neg[g]),
        .zero_coord(zero_c[g]),
        .tool_offset(tofs[g]),
        .target(target[g]),
        .home_start(home_start[g]),
        .move_start(move_start[g]),
        .jog_pos(jog_pos[g]),
        .jog_neg(jog_neg[g]),
        .dec_sw(dec_sw[g]),
        .zero_sw(zero_sw[g]),
        .step(ax_step[g]),
        .dir(ax_dir[g]),
        .homing(ax_homing[g]),
        .homed(ax_homed[g]),
        .search_slow(ax_slow[g]),
        .method(ax_method[2*g+1:2*g]),
        .alarm_pulse(ax_alarm[4*g+3:4*g]),
        .mcoord(ax_mcoord[CW*g+CW-1:CW*g])
      );
      always @* begin
        // Reference returns use machine coordinates, so tool offset plays no part.
        case (tgt_sel)
          2'h1: target[g] = ref1[g];
          2'h2: target[g] = ref2[g];
          2'h3: target[g] = ref3[g];
          default: target[g] = zero_c[g];
        endcase
      end
    end
  endgenerate

  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      `AHSL_OFF_SENSOR: next_rdata = {24'h00_0000, sensor_cfg};
      `AHSL_OFF_DIRCFG: next_rdata = {24'h00_0000, dir_cfg};
      `AHSL_OFF_CTRL: next_rdata = {30'h0000_0000, mode};
      `AHSL_OFF_STATUS: next_rdata = {17'h0_0000, ax_method, ax_slow, ax_homed, ax_homing};
      `AHSL_OFF_ALARM: next_rdata = {19'h0_0000, alarm};
      `AHSL_OFF_PRIV: next_rdata = {29'h0000_0000, priv};
      `AHSL_OFF_AXSEL: next_rdata = {30'h0000_0000, axsel};
      `AHSL_OFF_TNPOS: next_rdata = tn_pos[axsel];
      `AHSL_OFF_TNNEG: next_rdata = tn_neg[axsel];
      `AHSL_OFF_MCPOS: next_rdata = mc_pos[axsel];
      `AHSL_OFF_MCNEG: next_rdata = mc_neg[axsel];
      `AHSL_OFF_ZEROC: next_rdata = zero_c[axsel];
      `AHSL_OFF_REF1: next_rdata = ref1[axsel];
      `AHSL_OFF_REF2: next_rdata = ref2[axsel];
      `AHSL_OFF_REF3: next_rdata = ref3[axsel];
      `AHSL_OFF_LOWSPD: next_rdata = low_speed;
      `AHSL_OFF_INITSPD: next_rdata = init_speed;
      `AHSL_OFF_MCOORD: next_rdata = ax_mcoord[CW*axsel +: CW];
      `AHSL_OFF_TOFS: next_rdata = tofs[axsel];
      // Greyed functions read back as zero grant bits.
      `AHSL_OFF_OPGRANT: next_rdata = {22'h00_0000, op_req_ok, op_allowed};
      `AHSL_OFF_USBWLVL: next_rdata = {29'h0000_0000, usb_wlevel};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      sensor_cfg <= `AHSL_CFG_RST;
      dir_cfg <= `AHSL_CFG_RST;
      mode <= `AHSL_MODE_EDIT;
      priv <= `AHSL_LVL_NONE;
      axsel <= 2'h0;
      low_speed <= {CW{1'b0}};
      init_speed <= {CW{1'b0}};
      alarm <= 13'h0000;
      op_req_ok <= 5'h00;
      usb_wlevel <= `AHSL_LVL_MFR;
      upg_pending <= 1'b0;
      tgt_sel <= 2'h0;
      home_start <= 3'h0;
      move_start <= 3'h0;
      jog_pos <= 3'h0;
      jog_neg <= 3'h0;
      step <= 3'h0;
      dir <= 3'h0;
      search_speed <= {CW{1'b0}};
      for (i = 0; i < 3; i = i + 1) begin
        tn_pos[i] <= {CW{1'b0}};
        tn_neg[i] <= {CW{1'b0}};
        mc_pos[i] <= {CW{1'b0}};
        mc_neg[i] <= {CW{1'b0}};
        zero_c[i] <= {CW{1'b0}};
        ref1[i] <= {CW{1'b0}};
        ref2[i] <= {CW{1'b0}};
        ref3[i] <= {CW{1'b0}};
        tofs[i] <= {CW{1'b0}};
      end
    end else begin
      dph_valid <= ap_valid;
      dph_write <= hwrite;
      if (ap_valid) begin
        dph_addr <= haddr;
      end
      hresp <= 1'b0;
      hreadyout <= 1'b1;
      // Read data is decoded in the address phase so it stands through the data phase.
      // A read straight after a write to the same register returns the value before it.
      if (ap_valid && !hwrite) begin
        hrdata <= next_rdata;
      end
      home_start <= 3'h0;
      move_start <= 3'h0;
      step <= ax_step;
      dir <= ax_dir;
      // Zero search runs at the slower of the two speeds.
      search_speed <= (|ax_slow) ? ((low_speed < init_speed) ? low_speed : init_speed)
                                 : {CW{1'b0}};
      if (wr) begin
        case (dph_addr)
          `AHSL_OFF_SENSOR: sensor_cfg <= hwdata[7:0];
          `AHSL_OFF_DIRCFG: dir_cfg <= hwdata[7:0];
          `AHSL_OFF_CTRL: begin
            mode <= hwdata[`AHSL_C_MODE_LSB+1:`AHSL_C_MODE_LSB];
            jog_pos <= hwdata[12:10];
            jog_neg <= hwdata[15:13];
            // Escape clears a pending upgrade; edit before that sets the alarm, which only an alarm register write or reset clears.
            if (hwdata[`AHSL_C_ESC]) begin
              upg_pending <= 1'b0;
            end
            if (hwdata[`AHSL_C_UPGDONE] && op_allowed[3]) begin
              upg_pending <= 1'b1;
            end
            if (hwdata[`AHSL_C_EDIT] && upg_pending && !hwdata[`AHSL_C_ESC]) begin
              alarm[`AHSL_A_UPG] <= 1'b1;
            end
            if (hwdata[`AHSL_C_G28]) begin
              tgt_sel <= 2'h0;
              home_start <= 3'h7;
            end else if (hwdata[`AHSL_C_HOMEKEY]) begin
              tgt_sel <= 2'h0;
              // Axes with no switches honour the key only when enabled.
              home_start <= has_sw | {3{sensor_cfg[`AHSL_KEYEN_BIT]}};
            end else if (hwdata[`AHSL_C_REFRET] && mode != `AHSL_MODE_EDIT) begin
              tgt_sel <= 2'h1;
              move_start <= 3'h7;
            end else if (hwdata[`AHSL_C_G30] && mode == `AHSL_MODE_AUTO) begin
              tgt_sel <= hwdata[`AHSL_C_G30SEL] ? 2'h3 : 2'h2;
              move_start <= hwdata[18:16];
            end
          end
          `AHSL_OFF_ALARM: alarm <= alarm & ~hwdata[12:0];
          `AHSL_OFF_PRIV: priv <= hwdata[2:0];
          `AHSL_OFF_AXSEL: axsel <= (hwdata[1:0] == 2'h3) ? 2'h0 : hwdata[1:0];
          `AHSL_OFF_TNPOS: tn_pos[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_TNNEG: tn_neg[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_MCPOS: mc_pos[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_MCNEG: mc_neg[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_ZEROC: zero_c[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_REF1: ref1[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_REF2: ref2[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_REF3: ref3[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_LOWSPD: low_speed <= hwdata[CW-1:0];
          `AHSL_OFF_INITSPD: init_speed <= hwdata[CW-1:0];
          `AHSL_OFF_TOFS: tofs[axsel] <= hwdata[CW-1:0];
          `AHSL_OFF_OPREQ: begin
            op_req_ok <= hwdata[4:0] & op_allowed;
          end
          `AHSL_OFF_USBWLVL: begin
            usb_wlevel <= hwdata[2:0];
            op_req_ok[4] <= (priv <= hwdata[2:0]);
          end
          default: begin
          end
        endcase
      end
      // New alarm events win over a software clear in the same cycle.
      alarm[11:0] <= (wr && dph_addr == `AHSL_OFF_ALARM ? alarm[11:0] & ~hwdata[11:0]
                                                      : alarm[11:0]) | ax_alarm;
    end
  end
endmodule

// [ahsl_map.vh]
// Register map, field positions, reset values and codes for the axis homing and limit block.
// Notes on behaviour
// - At or past positive tool-nose limit in jog/auto, block positive motion and alarm.
// - At or past positive machine limit in jog/auto, block positive motion and alarm.
// - Negative side mirrors both checks; negative request at negative limit alarms.
// - Zero fitted and modify bit clear: load machine-zero coordinate on zero signal.
// - Zero search speed is the lower of zero-return low speed and initial speed.
// - Bits 7,6,5 of sensor config mark deceleration switch fitted on Z,X,Y.
// - Bits 4,3,2 of sensor config mark zero switch fitted on Z,X,Y.
// - Method 1: deceleration signal first, then zero signal, locates machine zero.
// - Method 2: deceleration signal alone locates machine zero.
// - Method 3: zero signal alone locates machine zero.
// - Method 4: move to parameter zero coordinates without any sensor.
// - No machine zero and key-enable 0: ignore panel home key, G28 still runs.
// - No machine zero and key-enable 1: panel home key homes by method 4.
// - Forbidden functions are shown greyed and refused.
// - Stepper or servo parameter initialization only at level 1.
// - Manufacturer parameter extraction and solidifying at levels 1 to 3, not 4.
// - Software update and whole memory update only at level 1.
// - USB send allowed at all levels; USB receive per parameter write level.
// - Program reference return moves to stored reference, unaffected by tool offset.
// - G30 in auto returns the axis to the second or third reference point.
// - After USB upgrade, escape or reset needed before editing, else alarm.
// - Direction bits 7,6,5 choose Z,X,Y zero search: 0 positive, 1 negative.
// - Level bits 4,3,2 choose active deceleration level: 0 low, 1 high.
`ifndef AHSL_MAP_VH
`define AHSL_MAP_VH
`define AHSL_OFF_SENSOR 12'h000
`define AHSL_OFF_DIRCFG 12'h004
`define AHSL_OFF_CTRL 12'h008
`define AHSL_OFF_STATUS 12'h00c
`define AHSL_OFF_ALARM 12'h010
`define AHSL_OFF_PRIV 12'h014
`define AHSL_OFF_AXSEL 12'h018
`define AHSL_OFF_TNPOS 12'h01c
`define AHSL_OFF_TNNEG 12'h020
`define AHSL_OFF_MCPOS 12'h024
`define AHSL_OFF_MCNEG 12'h028
`define AHSL_OFF_ZEROC 12'h02c
`define AHSL_OFF_REF1 12'h030
`define AHSL_OFF_REF2 12'h034
`define AHSL_OFF_REF3 12'h038
`define AHSL_OFF_LOWSPD 12'h03c
`define AHSL_OFF_INITSPD 12'h040
`define AHSL_OFF_MCOORD 12'h044
`define AHSL_OFF_TOFS 12'h048
`define AHSL_OFF_OPREQ 12'h04c
`define AHSL_OFF_OPGRANT 12'h050
`define AHSL_OFF_USBWLVL 12'h054
// Sensor config fields: decel-present base bit 5, zero-present base bit 2, key enable bit 0.
`define AHSL_DEC_LSB 5
`define AHSL_ZER_LSB 2
`define AHSL_KEYEN_BIT 0
// Direction config fields: direction base bit 5, level base bit 2, no-modify bit 1.
`define AHSL_DIR_LSB 5
`define AHSL_LVL_LSB 2
`define AHSL_NOMOD_BIT 1
`define AHSL_CFG_RST 8'h00
// Privilege levels.
`define AHSL_LVL_MFR 3'h1
`define AHSL_LVL_OPR 3'h3
`define AHSL_LVL_NONE 3'h4
// Control register fields.
`define AHSL_C_MODE_LSB 0
`define AHSL_C_HOMEKEY 2
`define AHSL_C_G28 3
`define AHSL_C_REFRET 4
`define AHSL_C_G30 5
`define AHSL_C_G30SEL 6
`define AHSL_C_ESC 7
`define AHSL_C_UPGDONE 8
`define AHSL_C_EDIT 9
// Working modes.
`define AHSL_MODE_EDIT 2'h0
`define AHSL_MODE_JOG 2'h1
`define AHSL_MODE_AUTO 2'h2
// Homing method codes.
`define AHSL_M1 2'h0
`define AHSL_M2 2'h1
`define AHSL_M3 2'h2
`define AHSL_M4 2'h3
// Alarm bits per axis: tool-nose pos, tool-nose neg, machine pos, machine neg; then the upgrade alarm bit.
`define AHSL_A_TNP 0
`define AHSL_A_TNN 1
`define AHSL_A_MCP 2
`define AHSL_A_MCN 3
`define AHSL_A_UPG 12
`endif

// [ahsl_axis.v]
// One axis: homing sequencer, limit gate and coordinate tracking.
`timescale 1ns/1ns
module ahsl_axis #(
  parameter CW = 32
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Configuration.
  input wire dec_fitted,
  input wire zero_fitted,
  input wire dir_neg,
  input wire dec_level,
  input wire no_modify,
  input wire jog_auto,
  input wire [CW-1:0] tn_pos_limit,
  input wire [CW-1:0] tn_neg_limit,
  input wire [CW-1:0] mc_pos_limit,
  input wire [CW-1:0] mc_neg_limit,
  input wire [CW-1:0] zero_coord,
  input wire [CW-1:0] tool_offset,
  input wire [CW-1:0] target,
  // Requests.
  input wire home_start,
  input wire move_start,
  input wire jog_pos,
  input wire jog_neg,
  // Switches.
  input wire dec_sw,
  input wire zero_sw,
  // Results.
  output reg step,
  output reg dir,
  output reg homing,
  output reg homed,
  output reg search_slow,
  output reg [1:0] method,
  output reg [3:0] alarm_pulse,
  output reg [CW-1:0] mcoord
);
  localparam S_IDLE = 3'h0;
  localparam S_DEC = 3'h1;
  localparam S_ZERO = 3'h2;
  localparam S_MOVE = 3'h3;
  localparam S_DONE = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] next_method;
  wire [CW-1:0] tncoord;
  wire at_tn_pos;
  wire at_tn_neg;
  wire at_mc_pos;
  wire at_mc_neg;
  wire dec_hit;
  wire want_pos;
  wire want_neg;
  wire allow_pos;
  wire allow_neg;
  wire move_dir_neg;
  wire move_dir_pos;
  assign tncoord = mcoord + tool_offset;
  // Limits are checked combinationally every cycle ahead of the step register.
  assign at_tn_pos = $signed(tncoord) >= $signed(tn_pos_limit);
  assign at_mc_pos = $signed(mcoord) >= $signed(mc_pos_limit);
  assign at_tn_neg = $signed(tncoord) <= $signed(tn_neg_limit);
  assign at_mc_neg = $signed(mcoord) <= $signed(mc_neg_limit);
  assign dec_hit = (dec_sw == dec_level);
  assign move_dir_neg = $signed(target) < $signed(mcoord);
  // A move asks for no step once it stands on its target, so it never overshoots.
  assign move_dir_pos = $signed(target) > $signed(mcoord);
  assign want_pos = (state == S_IDLE) ? jog_pos : ((state == S_MOVE) ? move_dir_pos : !dir_neg);
  assign want_neg = (state == S_IDLE) ? jog_neg : ((state == S_MOVE) ? move_dir_neg : dir_neg);
  // Switch searches travel toward their switches, so only idle jog and S_MOVE motion (method 4 homing included) is gated, in jog or auto mode.
  assign allow_pos = !(jog_auto && (state == S_IDLE || state == S_MOVE) && (at_tn_pos || at_mc_pos));
  assign allow_neg = !(jog_auto && (state == S_IDLE || state == S_MOVE) && (at_tn_neg || at_mc_neg));

  always @* begin
    case ({dec_fitted, zero_fitted})
      2'b11: next_method = `AHSL_M1;
      2'b10: next_method = `AHSL_M2;
      2'b01: next_method = `AHSL_M3;
      default: next_method = `AHSL_M4;
    endcase
  end

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (home_start) begin
          if (next_method == `AHSL_M1 || next_method == `AHSL_M2) begin
            next_state = S_DEC;
          end else if (next_method == `AHSL_M3) begin
            next_state = S_ZERO;
          end else begin
            next_state = S_MOVE;
          end
        end else if (move_start) begin
          next_state = S_MOVE;
        end
      end
      S_DEC: begin
        if (dec_hit) begin
          next_state = (method == `AHSL_M1) ? S_ZERO : S_DONE;
        end
      end
      S_ZERO: begin
        if (zero_sw) begin
          next_state = S_DONE;
        end
      end
      S_MOVE: begin
        if (mcoord == target) begin
          next_state = S_DONE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      method <= `AHSL_M4;
      step <= 1'b0;
      dir <= 1'b0;
      homing <= 1'b0;
      homed <= 1'b0;
      search_slow <= 1'b0;
      alarm_pulse <= 4'h0;
      mcoord <= {CW{1'b0}};
    end else begin
      state <= next_state;
      // The method follows the presence bits while idle and is frozen during a run.
      if (state == S_IDLE) begin
        method <= next_method;
      end
      if (state == S_IDLE && home_start) begin
        homing <= 1'b1;
      end
      if (state == S_DONE) begin
        homing <= 1'b0;
        if (homing) begin
          homed <= 1'b1;
        end
      end
      search_slow <= (next_state == S_ZERO);
      alarm_pulse <= 4'h0;
      step <= 1'b0;
      if (state != S_DONE) begin
        if (want_pos && allow_pos) begin
          step <= 1'b1;
          dir <= 1'b0;
          mcoord <= mcoord + {{(CW-1){1'b0}}, 1'b1};
        end else if (want_neg && allow_neg) begin
          step <= 1'b1;
          dir <= 1'b1;
          mcoord <= mcoord - {{(CW-1){1'b0}}, 1'b1};
        end
        if (want_pos && !allow_pos) begin
          alarm_pulse[`AHSL_A_TNP] <= at_tn_pos;
          alarm_pulse[`AHSL_A_MCP] <= at_mc_pos;
        end
        if (want_neg && !allow_neg) begin
          alarm_pulse[`AHSL_A_TNN] <= at_tn_neg;
          alarm_pulse[`AHSL_A_MCN] <= at_mc_neg;
        end
      end
      if (state == S_ZERO && zero_sw && !no_modify) begin
        mcoord <= zero_coord;
      end
    end
  end
endmodule

// [ahsl_properties.sv]
// Concurrent checks on the ports of the axis homing and limit block.
`timescale 1ns/1ns
module ahsl_props #(
  parameter CW = 32
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Bus requests.
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Bus answers.
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Drives.
  input wire [CW-1:0] search_speed
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && htrans[1] && hready;
  wire rdt = tk && !hwrite;
  reg wp;
  reg [11:0] wa;
  reg [31:0] lo;
  reg [31:0] ini;
  reg [31:0] priv;
  wire [31:0] mn = (lo < ini) ? lo : ini;
  // Shadows take the write data at the end of the data phase, as the slave does.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      wa <= 12'h000;
      lo <= 32'h0;
      ini <= 32'h0;
      priv <= 32'h4;
    end else begin
      wp <= tk && hwrite;
      wa <= haddr;
      if (wp && wa == 12'h03c) lo <= hwdata;
      if (wp && wa == 12'h040) ini <= hwdata;
      if (wp && wa == 12'h014) priv <= hwdata;
    end
  end
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response given");
  property p_unmap; rdt && haddr >= 12'h058 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stand; !$past(rdt) |-> $stable(hrdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_speed; search_speed != 0 |-> search_speed == mn[CW-1:0]; endproperty
  a_speed: assert property (p_speed) else $error("search speed not the lower one");
  property p_prv; rdt && haddr == 12'h014 |=> hrdata[2:0] == priv[2:0]; endproperty
  a_prv: assert property (p_prv) else $error("privilege level readback wrong");
  property p_gr1; rdt && haddr == 12'h050 && priv[2:0] == 3'h1 |=> hrdata[4:0] == 5'h1f;
  endproperty
  a_gr1: assert property (p_gr1) else $error("level one lacks a grant");
  property p_gr4; rdt && haddr == 12'h050 && priv[2:0] == 3'h4 |=> $countones(hrdata[4:0]) <= 1;
  endproperty
  a_gr4: assert property (p_gr4) else $error("level four over granted");
endmodule

// [ahsl_drive_model.sv]
// Behavioural axis drives and homing switches for the three axes.
`timescale 1ns/1ns
module ahsl_drive_model #(
  parameter DEC_AT = 6,
  parameter ZERO_AT = 9
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Drive commands.
  input wire [2:0] step,
  input wire [2:0] dir,
  // Active deceleration level per axis.
  input wire [2:0] dec_level,
  // Switches.
  output reg [2:0] dec_sw,
  output reg [2:0] zero_sw
);
  integer pos [0:2];
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    for (i = 0; i < 3; i = i + 1) begin
      if (!hresetn) pos[i] = 0;
      else if (step[i]) pos[i] = dir[i] ? pos[i] - 1 : pos[i] + 1;
      dec_sw[i] <= (pos[i] >= DEC_AT) ? dec_level[i] : ~dec_level[i];
      // The zero mark sits clear of the deceleration edge so they never coincide.
      zero_sw[i] <= (pos[i] >= ZERO_AT) && (pos[i] < ZERO_AT + 4);
    end
  end
endmodule

// [axis_homing_softlimit_control_tb.sv]
// Self-checking bench for the axis homing and limit block.
`timescale 1ns/1ns
module axis_homing_softlimit_control_tb;
  logic hclk, hresetn, hsel, hwrite, seen = 1'b0;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, r;
  wire hready, hreadyout, hresp;
  wire [31:0] hrdata, search_speed;
  wire [2:0] dec_sw, zero_sw, step, dir;
  int n_fail = 0, comparisons = 0, nstep = 0, cyc = 0, i;
  logic [7:0] cfg_t [5] = '{8'hfc, 8'he0, 8'h1c, 8'h00, 8'hd4};
  logic [5:0] mth_t [5] = '{6'h00, 6'h15, 6'h2a, 6'h3f, 6'h24};
  assign hready = hreadyout;
  ahsl_top i_ahsl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dec_sw(dec_sw),
    .zero_sw(zero_sw), .step(step), .dir(dir), .search_speed(search_speed));
  ahsl_drive_model i_ahsl_drive_model (.hclk(hclk), .hresetn(hresetn), .step(step),
    .dir(dir), .dec_level(3'b001), .dec_sw(dec_sw), .zero_sw(zero_sw));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (step[0] === 1'b1) nstep <= nstep + 1;
    if (search_speed === 32'd3) seen <= 1'b1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // One single word transfer; read data lands in r.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
    end
  endtask
  task rst;
    begin
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwdata = 32'h0;
    rst;
    for (i = 0; i < 5; i++) begin
      bus(1, 12'h000, {24'h0, cfg_t[i]});
      bus(0, 12'h000, 32'h0);
      chk(r, {24'h0, cfg_t[i]});
      bus(0, 12'h00c, 32'h0);
      chk({26'h0, r[14:9]}, {26'h0, mth_t[i]});
    end
    rst;
    bus(0, 12'h000, 32'h0);
    chk(r, 32'h0);
    bus(0, 12'h014, 32'h0);
    chk(r, 32'h4);
    bus(1, 12'h008, 32'h5);
    repeat (10) @(posedge hclk);
    bus(0, 12'h00c, 32'h0);
    chk({29'h0, r[5:3]}, 32'h0);
    bus(1, 12'h008, 32'h1);
    bus(1, 12'h000, 32'h1);
    bus(1, 12'h008, 32'h5);
    bus(1, 12'h008, 32'h1);
    repeat (10) @(posedge hclk);
    bus(0, 12'h00c, 32'h0);
    chk({29'h0, r[5:3]}, 32'h7);
    bus(1, 12'h008, 32'h401);
    repeat (20) @(posedge hclk);
    bus(1, 12'h008, 32'h1);
    bus(0, 12'h010, 32'h0);
    chk({28'h0, r[3:0]}, 32'h5);
    chk(nstep, 0);
    bus(1, 12'h010, 32'hf);
    bus(0, 12'h010, 32'h0);
    chk(r, 32'h0);
    bus(1, 12'h008, 32'h2001);
    repeat (20) @(posedge hclk);
    bus(1, 12'h008, 32'h1);
    bus(0, 12'h010, 32'h0);
    chk({28'h0, r[3:0]}, 32'ha);
    bus(1, 12'h020, 32'hffffff00);
    bus(1, 12'h028, 32'hffffff00);
    bus(1, 12'h010, 32'hf);
    bus(1, 12'h008, 32'h2001);
    repeat (20) @(posedge hclk);
    chk({31'h0, dir[0]}, 32'h1);
    bus(1, 12'h008, 32'h1);
    bus(0, 12'h010, 32'h0);
    chk(r, 32'h0);
    chk(nstep > 0, 1);
    bus(1, 12'h000, 32'h90);
    bus(1, 12'h004, 32'h10);
    bus(1, 12'h02c, 32'h100);
    bus(1, 12'h03c, 32'h5);
    bus(1, 12'h040, 32'h3);
    bus(1, 12'h008, 32'ha);
    bus(1, 12'h008, 32'h2);
    r = 32'h1;
    for (i = 0; i < 400 && r[0] !== 1'b0; i++) bus(0, 12'h00c, 32'h0);
    chk({29'h0, r[5:3]}, 32'h7);
    bus(1, 12'h044, 32'hdead);
    bus(0, 12'h044, 32'h0);
    chk(r, 32'h100);
    chk(seen, 1);
    bus(1, 12'h058, 32'hffffffff);
    bus(0, 12'h058, 32'h0);
    chk(r, 32'h0);
    for (i = 1; i < 5; i++) begin
      bus(1, 12'h014, i);
      bus(0, 12'h050, 32'h0);
      chk(r, (i == 1) ? 32'h1f : ((i == 4) ? 32'h10 : 32'h16));
    end
    bus(1, 12'h04c, 32'h1f);
    bus(0, 12'h050, 32'h0);
    chk(r, 32'h210);
    bus(1, 12'h054, 32'h3);
    bus(0, 12'h050, 32'h0);
    chk(r, 32'h10);
    bus(1, 12'h014, 32'h1);
    bus(1, 12'h008, 32'h100);
    bus(1, 12'h008, 32'h200);
    bus(0, 12'h010, 32'h0);
    chk(r & 32'h1000, 32'h1000);
    bus(1, 12'h010, 32'h1000);
    bus(1, 12'h008, 32'h80);
    bus(1, 12'h008, 32'h200);
    bus(0, 12'h010, 32'h0);
    chk(r, 32'h0);
    give_verdict;
  end
endmodule
bind ahsl_top ahsl_props #(.CW(CW)) i_ahsl_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .search_speed(search_speed));
